// *** sras_top.sv ***
`timescale 1ns/100ps
module sras_top
	import sras_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        sdi,
	input  wire logic        cpol,
	input  wire logic        cpha,
	output logic             sdo,
	output logic             sdo_oe,
	output logic [13:0]      reg_addr,
	output logic [7:0]       reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [7:0]  reg_rdata,
	output logic             order_lsb
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [SRAS_SYNC_W-1:0] sync_q;
	logic                   cs_n_s;
	logic                   cpol_s;
	logic                   cpha_s;
	logic                   rd_tgl_s;
	logic                   wr_tgl_s;

	logic                   inv_reg;
	logic                   inv_next;
	logic                   lsb_reg;
	logic                   lsb_next;
	logic [7:0]             order_reg;
	logic [7:0]             order_next;
	logic                   rd_seen_reg;
	logic                   rd_seen_next;
	logic                   wr_seen_reg;
	logic                   wr_seen_next;
	logic [13:0]            addr_o_reg;
	logic [13:0]            addr_o_next;
	logic [7:0]             wdata_o_reg;
	logic [7:0]             wdata_o_next;
	logic                   wr_o_reg;
	logic                   wr_o_next;
	logic                   rd_o_reg;
	logic                   rd_o_next;
	logic [7:0]             rdata_reg;
	logic [7:0]             rdata_next;
	sras_sys_state_t        sy_reg;
	sras_sys_state_t        sy_next;

	logic                   sclk_int;
	logic                   link_clr;
	sras_link_state_t       lk_reg;
	sras_link_state_t       lk_next;
	logic [3:0]             cnt_reg;
	logic [3:0]             cnt_next;
	logic [15:0]            sh_reg;
	logic [15:0]            sh_next;
	logic                   rw_reg;
	logic                   rw_next;
	logic                   burst_reg;
	logic                   burst_next;
	logic [13:0]            addr_reg;
	logic [13:0]            addr_next;
	logic                   rd_fire;
	logic                   wr_fire;
	logic [13:0]            fire_addr;
	logic [7:0]             fire_data;
	logic [15:0]            hdr_word;
	logic [7:0]             rx_byte;

	logic                   rd_tgl_reg;
	logic                   rd_tgl_next;
	logic                   wr_tgl_reg;
	logic                   wr_tgl_next;
	logic [13:0]            ev_addr_reg;
	logic [13:0]            ev_addr_next;
	logic [7:0]             ev_data_reg;
	logic [7:0]             ev_data_next;

	logic                   tx_active;
	logic                   tx_load;
	logic [7:0]             tx_byte;

	// ----------------------------------------------------------------
	// pin and toggle synchronisers
	// ----------------------------------------------------------------
	sras_sync #(
		.WIDTH   (SRAS_SYNC_W)
	) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d_async ({cs_n, cpol, cpha, rd_tgl_reg, wr_tgl_reg}),
		.q_sync  (sync_q)
	);

	assign cs_n_s   = sync_q[4];
	assign cpol_s   = sync_q[3];
	assign cpha_s   = sync_q[2];
	assign rd_tgl_s = sync_q[1];
	assign wr_tgl_s = sync_q[0];

	// ----------------------------------------------------------------
	// system side
	// ----------------------------------------------------------------
	// mode bits follow their sources only while the link is idle, so a
	// transaction never sees its clock edge or bit order change midway
	always_comb begin
		inv_next = inv_reg;
		lsb_next = lsb_reg;
		if (cs_n_s) begin
			inv_next = cpol_s ^ cpha_s;
			lsb_next = order_reg[SRAS_ORDER_LSB_A]
				| order_reg[SRAS_ORDER_LSB_B];
		end
	end

	// serviced events: writes first, a pending read waits one cycle
	always_comb begin
		order_next   = order_reg;
		rd_seen_next = rd_seen_reg;
		wr_seen_next = wr_seen_reg;
		addr_o_next  = addr_o_reg;
		wdata_o_next = wdata_o_reg;
		wr_o_next    = 1'b0;
		rd_o_next    = 1'b0;
		rdata_next   = rdata_reg;
		sy_next      = sy_reg;
		case (sy_reg)
			SRAS_SY_IDLE: begin
				if (wr_tgl_s != wr_seen_reg) begin
					wr_seen_next = wr_tgl_s;
					if (ev_addr_reg == SRAS_ORDER_ADDR) begin
						order_next = ev_data_reg;
					end else begin
						wr_o_next    = 1'b1;
						addr_o_next  = ev_addr_reg;
						wdata_o_next = ev_data_reg;
					end
				end else if (rd_tgl_s != rd_seen_reg) begin
					rd_seen_next = rd_tgl_s;
					if (ev_addr_reg == SRAS_ORDER_ADDR) begin
						rdata_next = order_reg;
					end else begin
						rd_o_next   = 1'b1;
						addr_o_next = ev_addr_reg;
						sy_next     = SRAS_SY_RDWAIT;
					end
				end
			end
			SRAS_SY_RDWAIT: begin
				rdata_next = reg_rdata; // one-cycle read latency
				sy_next    = SRAS_SY_IDLE;
			end
			default: begin
				sy_next = SRAS_SY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			inv_reg     <= 1'b0;
			lsb_reg     <= 1'b0;
			order_reg   <= SRAS_ORDER_RST;
			rd_seen_reg <= 1'b0;
			wr_seen_reg <= 1'b0;
			addr_o_reg  <= 14'h0000;
			wdata_o_reg <= 8'h00;
			wr_o_reg    <= 1'b0;
			rd_o_reg    <= 1'b0;
			rdata_reg   <= 8'h00;
			sy_reg      <= SRAS_SY_IDLE;
		end else begin
			inv_reg     <= inv_next;
			lsb_reg     <= lsb_next;
			order_reg   <= order_next;
			rd_seen_reg <= rd_seen_next;
			wr_seen_reg <= wr_seen_next;
			addr_o_reg  <= addr_o_next;
			wdata_o_reg <= wdata_o_next;
			wr_o_reg    <= wr_o_next;
			rd_o_reg    <= rd_o_next;
			rdata_reg   <= rdata_next;
			sy_reg      <= sy_next;
		end
	end

	assign reg_addr  = addr_o_reg;
	assign reg_wdata = wdata_o_reg;
	assign reg_wr    = wr_o_reg;
	assign reg_rd    = rd_o_reg;
	assign order_lsb = lsb_reg;

	// ----------------------------------------------------------------
	// link side
	// ----------------------------------------------------------------
	// sampling edge is always the rising edge of the folded clock;
	// select high holds the link logic except the event toggles in reset, a stopped clock is fine
	assign sclk_int = sclk ^ inv_reg;
	assign link_clr = cs_n | ~rst_n;

	assign hdr_word = {sh_reg[14:0], sdi};
	assign rx_byte  = lsb_reg ? sras_rev8(hdr_word[7:0]) : hdr_word[7:0];

	always_comb begin
		lk_next    = lk_reg;
		cnt_next   = cnt_reg + 4'h1;
		sh_next    = hdr_word;
		rw_next    = rw_reg;
		burst_next = burst_reg;
		addr_next  = addr_reg;
		rd_fire    = 1'b0;
		wr_fire    = 1'b0;
		fire_addr  = addr_reg;
		fire_data  = rx_byte;
		case (lk_reg)
			SRAS_LK_HDR: begin
				if (cnt_reg == SRAS_HDR_LAST) begin
					rw_next    = hdr_word[15];
					burst_next = hdr_word[0];
					addr_next  = lsb_reg ? sras_rev14(hdr_word[14:1])
						: hdr_word[14:1];
					cnt_next   = 4'h0;
					lk_next    = SRAS_LK_DATA;
					if (hdr_word[15] == SRAS_DIR_READ) begin
						rd_fire   = 1'b1;
						fire_addr = addr_next;
					end
				end
			end
			SRAS_LK_DATA: begin
				cnt_next = {1'b0, cnt_reg[2:0] + 3'h1};
				if (rw_reg == SRAS_DIR_READ) begin
					// prefetch next byte while this one shifts out
					if (cnt_reg[2:0] == SRAS_BYTE_FIRST && burst_reg == SRAS_BURST_ON) begin
						addr_next = addr_reg + 14'h0001;
						rd_fire   = 1'b1;
						fire_addr = addr_next;
					end
					if (cnt_reg[2:0] == SRAS_BYTE_LAST && burst_reg != SRAS_BURST_ON) begin
						lk_next = SRAS_LK_DONE;
					end
				end else if (cnt_reg[2:0] == SRAS_BYTE_LAST) begin
					// only a complete byte is posted
					wr_fire = 1'b1;
					if (burst_reg == SRAS_BURST_ON) begin
						addr_next = addr_reg + 14'h0001;
					end else begin
						lk_next = SRAS_LK_DONE;
					end
				end
			end
			SRAS_LK_DONE: begin
				cnt_next = cnt_reg; // extra clocks ignored until select rises
			end
			default: begin
				lk_next = SRAS_LK_HDR;
			end
		endcase
	end

	always_ff @(posedge sclk_int or posedge link_clr) begin
		if (link_clr) begin
			lk_reg    <= SRAS_LK_HDR;
			cnt_reg   <= 4'h0;
			sh_reg    <= 16'h0000;
			rw_reg    <= 1'b0;
			burst_reg <= 1'b0;
			addr_reg  <= 14'h0000;
		end else begin
			lk_reg    <= lk_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			rw_reg    <= rw_next;
			burst_reg <= burst_next;
			addr_reg  <= addr_next;
		end
	end

	// events survive select rising: a toggle reset there would look
	// like a fresh request on the system side
	always_comb begin
		rd_tgl_next  = rd_tgl_reg ^ rd_fire;
		wr_tgl_next  = wr_tgl_reg ^ wr_fire;
		ev_addr_next = ev_addr_reg;
		ev_data_next = ev_data_reg;
		if (rd_fire || wr_fire) begin
			ev_addr_next = fire_addr;
			ev_data_next = fire_data;
		end
	end

	always_ff @(posedge sclk_int or negedge rst_n) begin
		if (!rst_n) begin
			rd_tgl_reg  <= 1'b0;
			wr_tgl_reg  <= 1'b0;
			ev_addr_reg <= 14'h0000;
			ev_data_reg <= 8'h00;
		end else begin
			rd_tgl_reg  <= rd_tgl_next;
			wr_tgl_reg  <= wr_tgl_next;
			ev_addr_reg <= ev_addr_next;
			ev_data_reg <= ev_data_next;
		end
	end

	// ----------------------------------------------------------------
	// read data output
	// ----------------------------------------------------------------
	// read data is held stable by the system side well before it is used
	assign tx_active = (lk_reg == SRAS_LK_DATA) && (rw_reg == SRAS_DIR_READ);
	assign tx_load   = (cnt_reg[2:0] == SRAS_BYTE_FIRST);
	assign tx_byte   = lsb_reg ? sras_rev8(rdata_reg) : rdata_reg;

	sras_tx u_tx (
		.sclk_int  (sclk_int),
		.link_clr  (link_clr),
		.tx_active (tx_active),
		.tx_load   (tx_load),
		.tx_byte   (tx_byte),
		.sdo       (sdo),
		.sdo_oe    (sdo_oe)
	);

endmodule // sras_top

// *** sras_pkg.sv ***
package sras_pkg;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int SRAS_ADDR_W   = 14;
	localparam int SRAS_DATA_W   = 8;
	localparam int SRAS_HDR_BITS = 16;
	localparam int SRAS_SYNC_W   = 5;

	localparam logic [3:0] SRAS_HDR_LAST  = 4'hF;
	localparam logic [2:0] SRAS_BYTE_LAST = 3'h7;
	localparam logic [2:0] SRAS_BYTE_FIRST = 3'h0;

	localparam logic SRAS_DIR_READ = 1'b1;
	localparam logic SRAS_BURST_ON = 1'b1;

	// ----------------------------------------------------------------
	// bit-order control register
	// ----------------------------------------------------------------
	localparam logic [13:0] SRAS_ORDER_ADDR = 14'h3FFF;
	localparam logic [7:0]  SRAS_ORDER_RST  = 8'h00;
	localparam int          SRAS_ORDER_LSB_A = 3;
	localparam int          SRAS_ORDER_LSB_B = 4;

	// ----------------------------------------------------------------
	// state encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRAS_LK_HDR  = 2'b00,
		SRAS_LK_DATA = 2'b01,
		SRAS_LK_DONE = 2'b11
	} sras_link_state_t;

	typedef enum logic [1:0] {
		SRAS_SY_IDLE   = 2'b00,
		SRAS_SY_RDWAIT = 2'b01
	} sras_sys_state_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] sras_rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	function automatic logic [13:0] sras_rev14(input logic [13:0] v);
		logic [13:0] r;
		r = '0;
		for (int i = 0; i < 14; i++) begin
			r[i] = v[13-i];
		end
		return r;
	endfunction

endpackage

// *** sras_sync.sv ***
`timescale 1ns/100ps
// two-stage synchroniser, one bit per lane
module sras_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d_async,
	output logic      [WIDTH-1:0] q_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_sync_reg;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("sras_sync: WIDTH must be at least one");
		end
	endgenerate

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg   <= '0;
			q_sync_reg <= '0;
		end else begin
			meta_reg   <= d_async;
			q_sync_reg <= meta_reg;
		end
	end

	assign q_sync = q_sync_reg;

endmodule // sras_sync

// *** sras_tx.sv ***
`timescale 1ns/100ps
// read-data shifter on the output edge of the link clock
module sras_tx
	import sras_pkg::*;
(
	input  wire logic       sclk_int,
	input  wire logic       link_clr,
	input  wire logic       tx_active,
	input  wire logic       tx_load,
	input  wire logic [7:0] tx_byte,
	output logic            sdo,
	output logic            sdo_oe
);

	logic [7:0] sh_reg;
	logic [7:0] sh_next;
	logic       sdo_reg;
	logic       sdo_next;
	logic       oe_reg;
	logic       oe_next;

	// ----------------------------------------------------------------
	// output shifter
	// ----------------------------------------------------------------
	// drive only while a read byte is going out, float otherwise
	always_comb begin
		sh_next  = sh_reg;
		sdo_next = 1'b0;
		oe_next  = 1'b0;
		if (tx_active) begin
			oe_next = 1'b1;
			if (tx_load) begin
				sdo_next = tx_byte[7];
				sh_next  = {tx_byte[6:0], 1'b0};
			end else begin
				sdo_next = sh_reg[7];
				sh_next  = {sh_reg[6:0], 1'b0};
			end
		end
	end

	// chip select high clears the driver at once, no clock needed
	always_ff @(negedge sclk_int or posedge link_clr) begin
		if (link_clr) begin
			sh_reg  <= 8'h00;
			sdo_reg <= 1'b0;
			oe_reg  <= 1'b0;
		end else begin
			sh_reg  <= sh_next;
			sdo_reg <= sdo_next;
			oe_reg  <= oe_next;
		end
	end

	assign sdo    = sdo_reg;
	assign sdo_oe = oe_reg;

endmodule // sras_tx

// *** sras_regfile_model.sv ***
`timescale 1ns/100ps
// register file behind the register port of the block
module sras_regfile_model (
	input  wire logic        clk_sys,
	input  wire logic [13:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata
);
	logic [7:0] mem [int];

	initial reg_rdata = 8'h00;

	// ------------------------------------------------------------
	// storage and read answer
	// ------------------------------------------------------------
	// answers mid-cycle so the data stands at the edge after the strobe;
	// it churns otherwise, so a sample taken a cycle late is caught
	always @(negedge clk_sys) begin
		if (reg_wr) begin
			mem[reg_addr] = reg_wdata;
		end
		if (reg_rd) begin
			reg_rdata <= mem.exists(reg_addr) ? mem[reg_addr] : (reg_addr[7:0] ^ 8'hA5);
		end else begin
			reg_rdata <= ~reg_rdata;
		end
	end
endmodule // sras_regfile_model

// *** sras_top_sva.sv ***
`timescale 1ns/100ps
module sras_top_chk
	import sras_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        sclk,
	input wire logic        cs_n,
	input wire logic        sdi,
	input wire logic        cpol,
	input wire logic        cpha,
	input wire logic        sdo,
	input wire logic        sdo_oe,
	input wire logic [13:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        order_lsb
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// port relations
	// ------------------------------------------------------------
	a_oe_needs_select: assert property (sdo_oe |-> !cs_n)
		else $error("sdo driven while deselected");
	a_sdo_idle_zero: assert property (!sdo_oe |-> !sdo)
		else $error("sdo not zero while released");
	a_hdr_quiet_out: assert property ($fell(cs_n) |-> (!sdo_oe && !reg_wr && !reg_rd) [*8])
		else $error("activity during control word");
	a_strobe_single: assert property ((reg_wr || reg_rd) |=> !(reg_wr || reg_rd))
		else $error("register strobe longer than one cycle");
	a_strobe_apart: assert property (!(reg_wr && reg_rd))
		else $error("read and write together");
	a_order_internal: assert property ((reg_wr || reg_rd) |-> reg_addr != SRAS_ORDER_ADDR)
		else $error("order register leaked to port");
	// order may only move once select has been high a few cycles
	a_order_idle_only: assert property ($changed(order_lsb) |-> ($past(cs_n, 2) || $past(cs_n, 3) || $past(cs_n, 4)))
		else $error("bit order changed inside a transfer");
	a_wr_data_hold: assert property (reg_wr |=> $stable(reg_addr) && $stable(reg_wdata))
		else $error("write address or data moved");
	a_reset_quiet: assert property ($rose(rst_n) |-> !sdo_oe && !order_lsb && !reg_wr && !reg_rd)
		else $error("outputs active after reset");
endmodule // sras_top_chk

bind sras_top sras_top_chk u_chk (.*);

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	// half sclk period; slow so the read round trip fits in one half
	localparam int H = 163;
	logic        clk_sys, rst_n, sclk, cs_n, sdi, cpol, cpha;
	logic        sdo, sdo_oe, reg_wr, reg_rd, order_lsb;
	logic [13:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, ordr;
	logic [7:0]  em [int];
	logic [7:0]  wq [$];
	int          fails, checks_done;

	sras_top dut (.*);
	sras_regfile_model u_rf (.*);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// reference model and checks
	// ------------------------------------------------------------
	function automatic logic [7:0] exp_rd(input logic [13:0] a);
		if (a == 14'h3FFF) return ordr;
		return em.exists(a) ? em[a] : (a[7:0] ^ 8'hA5);
	endfunction

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// master side
	// ------------------------------------------------------------
	// one sclk bit; master samples sdo where the device samples sdi
	task automatic sb(input logic b, output logic r);
		if (cpha) begin
			sclk = ~cpol;
			sdi = b;
			#H;
			r = sdo_oe ? sdo : ~sdo; // released line reads wrong
			sclk = cpol;
			#H;
		end else begin
			sdi = b;
			#H;
			r = sdo_oe ? sdo : ~sdo;
			sclk = ~cpol;
			#H;
			sclk = cpol;
		end
	endtask

	// whole transfer; nbit below a byte multiple aborts mid-byte
	task automatic xfer(input logic rd, input logic [13:0] a, input logic bu, input int nbit);
		logic        r, lsb;
		logic [7:0]  v;
		logic [13:0] ad;
		lsb = ordr[3] | ordr[4];
		ad = a;
		v = 8'h00;
		@(posedge clk_sys);
		#2 cs_n = 1'b0;
		#H;
		sb(rd, r);
		for (int i = 0; i < 14; i++) sb(lsb ? a[i] : a[13-i], r);
		sb(bu, r);
		for (int i = 0; i < nbit; i++) begin
			int j;
			j = lsb ? i % 8 : 7 - i % 8;
			if (rd) begin
				sb(~sdi, r); // sdi is don't-care here, driven with its inverse
				v[j] = r;
			end else sb(wq[i/8][j], r);
			if (i % 8 == 7) begin
				if (rd) cmp(v, exp_rd(ad));
				else if (ad == 14'h3FFF) ordr = wq[i/8];
				else em[ad] = wq[i/8];
				ad = ad + 14'h0001;
			end
		end
		@(posedge clk_sys);
		#2 cs_n = 1'b1;
		repeat (10) @(posedge clk_sys);
		#2 cmp({7'h00, order_lsb}, {7'h00, ordr[3] | ordr[4]});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, sclk, cs_n, sdi, cpol, cpha} = 6'b001000;
		fails = 0;
		checks_done = 0;
		ordr = 8'h00;
		void'($urandom(32'h0E69));
		repeat (5) @(posedge clk_sys);
		#2 rst_n = 1'b1;
		repeat (6) @(posedge clk_sys);
		#2 cmp({sdo_oe, order_lsb, 6'h00}, 8'h00);
		xfer(1'b1, 14'h3FFF, 1'b0, 8);
		for (int m = 0; m < 4; m++) begin
			logic [13:0] a;
			cpol = m[1];
			cpha = m[0];
			sclk = cpol;
			repeat (5) @(posedge clk_sys);
			a = 14'($urandom % 32'h3FFF);
			wq = {8'($urandom)};
			xfer(1'b0, a, 1'b0, 8);
			xfer(1'b1, a, 1'b0, 8);
		end
		wq = {8'h3C};
		xfer(1'b0, 14'h0123, 1'b0, 5);
		xfer(1'b1, 14'h0123, 1'b0, 8);
		wq = {8'($urandom), 8'h00, 8'($urandom), 8'($urandom)};
		xfer(1'b0, 14'h3FFE, 1'b1, 32);
		xfer(1'b1, 14'h3FFE, 1'b1, 32);
		foreach (wq[k]) wq[k] = 8'h00;
		for (int k = 0; k < 3; k++) begin
			logic [13:0] a;
			wq = {(k == 0) ? 8'h08 : (k == 1) ? 8'h10 : 8'h00};
			xfer(1'b0, 14'h3FFF, 1'b0, 8);
			a = 14'($urandom % 32'h3FFF);
			wq = {8'($urandom), 8'($urandom)};
			xfer(1'b0, a, 1'b1, 16);
			xfer(1'b1, a, 1'b1, 16);
		end
		finish_test;
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk_sys);
		fails++;
		finish_test;
	end
endmodule // tb_top
